/* hw/dppr_bank.sv */
// Direct-page register bank: port data, direction, pull-up and keypad registers
`timescale 1ns/1ps
module dppr_bank (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic bus_fetch,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   output logic illegal_addr_reset,
   input wire logic [5:0] port_a_pin_in,
   input wire logic [7:0] port_b_pin_in,
   input wire logic auto_wakeup_event,
   input wire logic keypad_event,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   output logic [7:0] port_a_pullup,
   output logic osc_out_pin_enable,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic [7:0] port_b_pullup,
   output logic [7:0] keypad_irq_enable,
   output logic [7:0] keypad_irq_polarity,
   output logic [1:0] keypad_mode_mask
);
   typedef struct packed {
      dppr_pkg::dppr_ctrl_t ctrl;
      logic [7:0] rdata;
      logic illegal;
   } dppr_bank_state_t;

   dppr_bank_state_t state;
   dppr_bank_state_t next_state;
   dppr_pkg::dppr_bus_req_t req;
   logic [1:0] rst_sync;
   logic rst_int_n;
   logic [5:0] pa_in_s;
   logic [7:0] pb_in_s;
   logic [1:0] ev_s;
   logic reg_hit;
   logic ram_hit;
   logic implemented;
   logic [7:0] ram_mem [dppr_pkg::RAM_WORDS];
   logic [7:0] pa_pins;

   // Data registers survive reset, so they live outside the reset process
   dppr_pkg::dppr_data_t data_hold;
   logic wake_hold;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync[1];

   dppr_sync #(.WIDTH(6)) u_sync_pa (
      .clock(clock),
      .rst_n(rst_int_n),
      .async_in(port_a_pin_in),
      .sync_out(pa_in_s)
   );

   dppr_sync #(.WIDTH(8)) u_sync_pb (
      .clock(clock),
      .rst_n(rst_int_n),
      .async_in(port_b_pin_in),
      .sync_out(pb_in_s)
   );

   dppr_sync #(.WIDTH(2)) u_sync_ev (
      .clock(clock),
      .rst_n(rst_int_n),
      .async_in({auto_wakeup_event, keypad_event}),
      .sync_out(ev_s)
   );

   dppr_decode u_decode (
      .addr(bus_addr),
      .reg_hit(reg_hit),
      .ram_hit(ram_hit),
      .implemented(implemented)
   );

   always_comb begin
      req.rd = bus_rd;
      req.wr = bus_wr;
      req.fetch = bus_fetch;
      req.addr = bus_addr;
      req.wdata = bus_wdata;
   end

   // Direct-page RAM, reached by any addressing form
   always_ff @(posedge clock) begin
      if (req.wr && ram_hit) begin
         ram_mem[req.addr[6:0]] <= req.wdata;
      end
   end

   // Port A read: pin for inputs, latch for outputs; bit 2 always pin
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pa_pins[i] = state.ctrl.a_dir[i] ? data_hold.a_out[i] : pa_in_s[i];
      end
      pa_pins[7:6] = 2'b00;
   end

   always_comb begin
      next_state = state;
      next_state.illegal = 1'b0;
      next_state.rdata = dppr_pkg::RESET_ZERO;
      // Sticky keypad flag: set wins over acknowledge
      if (req.wr && req.addr == dppr_pkg::ADDR_KBD_SC && req.wdata[dppr_pkg::KBD_SC_ACK_BIT]) begin
         next_state.ctrl.kbd_sc[dppr_pkg::KBD_SC_FLAG_BIT] = 1'b0;
      end
      if (ev_s[0]) begin
         next_state.ctrl.kbd_sc[dppr_pkg::KBD_SC_FLAG_BIT] = 1'b1;
      end
      if (req.wr && reg_hit) begin
         unique case (req.addr)
            dppr_pkg::ADDR_PORT_A_DIR: begin
               next_state.ctrl.a_dir = req.wdata & dppr_pkg::MASK_PORT_A_DIR;
            end
            dppr_pkg::ADDR_PORT_B_DIR: begin
               next_state.ctrl.b_dir = req.wdata & dppr_pkg::MASK_FULL;
            end
            dppr_pkg::ADDR_PORT_A_PUE: begin
               next_state.ctrl.a_pue = req.wdata & dppr_pkg::MASK_PORT_A_PUE;
            end
            dppr_pkg::ADDR_PORT_B_PUE: begin
               next_state.ctrl.b_pue = req.wdata & dppr_pkg::MASK_FULL;
            end
            dppr_pkg::ADDR_KBD_SC: begin
               next_state.ctrl.kbd_sc[1:0] = req.wdata[1:0] & dppr_pkg::MASK_KBD_SC[1:0];
            end
            dppr_pkg::ADDR_KBD_EN: begin
               next_state.ctrl.kbd_en = req.wdata & dppr_pkg::MASK_KBD_EN;
            end
            dppr_pkg::ADDR_KBD_POL: begin
               next_state.ctrl.kbd_pol = req.wdata & dppr_pkg::MASK_KBD_POL;
            end
            default: begin
               // Data registers leave control state alone
            end
         endcase
      end
      if (req.rd) begin
         unique case (req.addr)
            dppr_pkg::ADDR_PORT_A_DATA: begin
               next_state.rdata = {1'b0, wake_hold, pa_pins[5:0]};
            end
            dppr_pkg::ADDR_PORT_B_DATA: begin
               for (int i = 0; i < 8; i++) begin
                  next_state.rdata[i] = state.ctrl.b_dir[i] ? data_hold.b_out[i] : pb_in_s[i];
               end
            end
            dppr_pkg::ADDR_PORT_A_DIR: next_state.rdata = state.ctrl.a_dir;
            dppr_pkg::ADDR_PORT_B_DIR: next_state.rdata = state.ctrl.b_dir;
            dppr_pkg::ADDR_PORT_A_PUE: next_state.rdata = state.ctrl.a_pue;
            dppr_pkg::ADDR_PORT_B_PUE: next_state.rdata = state.ctrl.b_pue;
            dppr_pkg::ADDR_KBD_SC: begin
               next_state.rdata = state.ctrl.kbd_sc & 8'h0B; // ack bit reads zero
            end
            dppr_pkg::ADDR_KBD_EN: next_state.rdata = state.ctrl.kbd_en;
            dppr_pkg::ADDR_KBD_POL: next_state.rdata = state.ctrl.kbd_pol;
            default: begin
               // RAM byte or zero for gaps
               next_state.rdata = ram_hit ? ram_mem[req.addr[6:0]] : dppr_pkg::RESET_ZERO;
            end
         endcase
      end
      // Fetch outside populated memory asks for an illegal-address reset
      if (req.fetch && !implemented) begin
         next_state.illegal = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_int_n) begin
      if (!rst_int_n) begin
         state.ctrl <= '0;
         state.rdata <= dppr_pkg::RESET_ZERO;
         state.illegal <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // Port data latches: no reset term, contents kept through reset
   always_ff @(posedge clock) begin
      if (req.wr && req.addr == dppr_pkg::ADDR_PORT_A_DATA) begin
         data_hold.a_out <= req.wdata & dppr_pkg::MASK_PORT_A_DATA;
      end
      if (req.wr && req.addr == dppr_pkg::ADDR_PORT_B_DATA) begin
         data_hold.b_out <= req.wdata;
      end
      if (ev_s[1]) begin
         wake_hold <= 1'b1;
      end else if (req.wr && req.addr == dppr_pkg::ADDR_PORT_A_DATA) begin
         wake_hold <= req.wdata[dppr_pkg::PORT_A_WAKE_BIT];
      end
   end

   always_comb begin
      bus_rdata = state.rdata;
      illegal_addr_reset = state.illegal;
      port_a_out = data_hold.a_out;
      port_a_oe = state.ctrl.a_dir;
      port_a_pullup = {2'b00, state.ctrl.a_pue[5:0]};
      osc_out_pin_enable = state.ctrl.a_pue[7];
      port_b_out = data_hold.b_out;
      port_b_oe = state.ctrl.b_dir;
      port_b_pullup = state.ctrl.b_pue;
      keypad_irq_enable = state.ctrl.kbd_en;
      keypad_irq_polarity = state.ctrl.kbd_pol;
      keypad_mode_mask = state.ctrl.kbd_sc[1:0];
   end
endmodule

/* include/dppr_pkg.sv */
// Package: offsets, field layouts, reset values and carriers of the direct-page register bank
package dppr_pkg;

   localparam logic [15:0] ADDR_PORT_A_DATA = 16'h0000;
   localparam logic [15:0] ADDR_PORT_B_DATA = 16'h0001;
   localparam logic [15:0] ADDR_PORT_A_DIR = 16'h0004;
   localparam logic [15:0] ADDR_PORT_B_DIR = 16'h0005;
   localparam logic [15:0] ADDR_PORT_A_PUE = 16'h000B;
   localparam logic [15:0] ADDR_PORT_B_PUE = 16'h000C;
   localparam logic [15:0] ADDR_KBD_SC = 16'h001A;
   localparam logic [15:0] ADDR_KBD_EN = 16'h001B;
   localparam logic [15:0] ADDR_KBD_POL = 16'h001C;
   localparam logic [15:0] DIRECT_PAGE_TOP = 16'h00FF;
   localparam logic [15:0] REG_AREA_TOP = 16'h003F;
   localparam logic [15:0] RAM_BASE = 16'h0080;

   // Writable bit masks
   localparam logic [7:0] MASK_PORT_A_DATA = 8'h7F;
   localparam logic [7:0] MASK_PORT_A_DIR = 8'h3B;
   localparam logic [7:0] MASK_PORT_A_PUE = 8'hBF;
   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam logic [7:0] MASK_KBD_SC = 8'h03;
   localparam logic [7:0] MASK_KBD_EN = 8'h7F;
   localparam logic [7:0] MASK_KBD_POL = 8'h3F;
   localparam int KBD_SC_ACK_BIT = 2;
   localparam int KBD_SC_FLAG_BIT = 3;
   localparam int PORT_A_WAKE_BIT = 6;

   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam int RAM_WORDS = 128;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic rd;
      logic wr;
      logic fetch;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dppr_bus_req_t;

   typedef struct packed {
      logic [7:0] a_dir;
      logic [7:0] b_dir;
      logic [7:0] a_pue;
      logic [7:0] b_pue;
      logic [7:0] kbd_sc;
      logic [7:0] kbd_en;
      logic [7:0] kbd_pol;
   } dppr_ctrl_t;

   typedef struct packed {
      logic [7:0] a_out;
      logic [7:0] b_out;
   } dppr_data_t;

endpackage

/* hw/dppr_sync.sv */
// Two-stage synchroniser for pin inputs and the wakeup and keypad events
`timescale 1ns/1ps
module dppr_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } dppr_sync_state_t;

   dppr_sync_state_t state;
   dppr_sync_state_t next_state;

   always_comb begin
      next_state.stage1 = async_in;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_out = state.stage2;
endmodule

/* hw/dppr_decode.sv */
// Address decoder: register hit, RAM hit and populated-address flag
`timescale 1ns/1ps
module dppr_decode (
   input wire logic [15:0] addr,
   output logic reg_hit,
   output logic ram_hit,
   output logic implemented
);
   function automatic logic is_reg(input logic [15:0] a);
      is_reg = (a == dppr_pkg::ADDR_PORT_A_DATA) || (a == dppr_pkg::ADDR_PORT_B_DATA) ||
               (a == dppr_pkg::ADDR_PORT_A_DIR) || (a == dppr_pkg::ADDR_PORT_B_DIR) ||
               (a == dppr_pkg::ADDR_PORT_A_PUE) || (a == dppr_pkg::ADDR_PORT_B_PUE) ||
               (a == dppr_pkg::ADDR_KBD_SC) || (a == dppr_pkg::ADDR_KBD_EN) ||
               (a == dppr_pkg::ADDR_KBD_POL);
   endfunction

   always_comb begin
      reg_hit = is_reg(addr);
      ram_hit = (addr >= dppr_pkg::RAM_BASE) && (addr <= dppr_pkg::DIRECT_PAGE_TOP);
      // Register area is populated; gap 0x40..0x7F and above the page are not here
      implemented = ram_hit || (addr <= dppr_pkg::REG_AREA_TOP);
   end
endmodule

/* verif/dppr_bank_props.sv */
// Bus-side assertions for the direct-page register bank
`timescale 1ns/1ps
module dppr_bank_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic bus_fetch,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic illegal_addr_reset,
   input wire logic [7:0] port_a_oe,
   input wire logic [7:0] port_b_oe,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_a_pullup,
   input wire logic osc_out_pin_enable,
   input wire logic [7:0] port_b_pullup
);
   default clocking dc @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic gap;
   logic bad;
   assign gap = bus_addr inside {[16'h0002:16'h0003], [16'h0006:16'h000A], [16'h000D:16'h0019]};
   assign bad = bus_addr > 16'h00FF || bus_addr inside {[16'h0040:16'h007F]};
   property p_a_dir;
      bus_wr && bus_addr == 16'h0004 |=> port_a_oe == ($past(bus_wdata) & 8'h3B);
   endproperty
   a_a_dir: assert property (p_a_dir) else $error("port a direction wrong");
   property p_b_dir;
      bus_rd && bus_addr == 16'h0005 |=> bus_rdata == $past(port_b_oe);
   endproperty
   a_b_dir: assert property (p_b_dir) else $error("port b direction read wrong");
   property p_b_data;
      bus_wr && bus_addr == 16'h0001 |=> port_b_out == $past(bus_wdata);
   endproperty
   a_b_data: assert property (p_b_data) else $error("port b latch wrong");
   property p_a_pue;
      bus_wr && bus_addr == 16'h000B |=>
         port_a_pullup == ($past(bus_wdata) & 8'h3F) && osc_out_pin_enable == $past(bus_wdata[7]);
   endproperty
   a_a_pue: assert property (p_a_pue) else $error("port a pull-up wrong");
   property p_b_pue;
      bus_wr && bus_addr == 16'h000C |=> port_b_pullup == $past(bus_wdata);
   endproperty
   a_b_pue: assert property (p_b_pue) else $error("port b pull-up wrong");
   property p_gap_wr;
      bus_wr && gap |=> $stable(port_a_oe) && $stable(port_b_oe) && $stable(port_b_pullup);
   endproperty
   a_gap_wr: assert property (p_gap_wr) else $error("gap write changed state");
   property p_gap_rd;
      bus_rd && gap |=> bus_rdata == 8'h00;
   endproperty
   a_gap_rd: assert property (p_gap_rd) else $error("gap read not zero");
   property p_bad_fetch;
      bus_fetch && bad |=> illegal_addr_reset;
   endproperty
   a_bad_fetch: assert property (p_bad_fetch) else $error("no illegal reset");
   property p_good_fetch;
      bus_fetch && bus_addr <= 16'h00FF && !bad |=> !illegal_addr_reset;
   endproperty
   a_good_fetch: assert property (p_good_fetch) else $error("spurious illegal reset");
   c_dir: cover property (bus_wr && bus_addr == 16'h0005);
   c_gap: cover property (bus_wr && gap);
   c_bad: cover property (bus_fetch && bad);
endmodule
bind dppr_bank dppr_bank_props u_props (.clock(clock), .rst_n(rst_n), .bus_rd(bus_rd),
   .bus_wr(bus_wr), .bus_fetch(bus_fetch), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_rdata(bus_rdata), .illegal_addr_reset(illegal_addr_reset), .port_a_oe(port_a_oe),
   .port_b_oe(port_b_oe), .port_b_out(port_b_out), .port_a_pullup(port_a_pullup),
   .osc_out_pin_enable(osc_out_pin_enable), .port_b_pullup(port_b_pullup));

/* verif/dppr_core_model.sv */
// Processor-core model driving the register bus
`timescale 1ns/1ps
module dppr_core_model (
   input wire logic clock,
   input wire logic [7:0] bus_rdata,
   output logic bus_rd,
   output logic bus_wr,
   output logic bus_fetch,
   output logic [15:0] bus_addr,
   output logic [7:0] bus_wdata
);
   initial begin
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_fetch = 1'b0;
      bus_addr = 16'hFFFF;
      bus_wdata = 8'h00;
   end
   // One access held for one cycle, then an idle cycle; full 16-bit address
   task automatic access(input logic r, input logic w, input logic f, input logic [15:0] a,
         input logic [7:0] d, output logic [7:0] q);
      @(negedge clock);
      bus_rd = r;
      bus_wr = w;
      bus_fetch = f;
      bus_addr = a;
      bus_wdata = d;
      @(negedge clock);
      q = bus_rdata;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_fetch = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask
endmodule

/* verif/test_direct_page_port_register_bank.sv */
// Testbench for the direct-page register bank
`timescale 1ns/1ps
module test_direct_page_port_register_bank;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic bus_rd, bus_wr, bus_fetch, illegal_addr_reset, osc_en;
   logic [15:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, a_out, a_oe, a_pu, b_out, b_oe, b_pu, k_en, k_pol, q;
   logic [1:0] k_mm;
   logic [5:0] pa_in = 6'h00;
   logic [7:0] pb_in = 8'h00;
   logic aw_ev = 1'b0;
   logic kb_ev = 1'b0;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [15:0] ra [7] = '{16'h0004, 16'h0005, 16'h000B, 16'h000C, 16'h001A, 16'h001B, 16'h001C};
   logic [7:0] rm [7] = '{8'h3B, 8'hFF, 8'hBF, 8'hFF, 8'h03, 8'h7F, 8'h3F};
   logic [15:0] gp [4] = '{16'h0002, 16'h0006, 16'h000D, 16'h0019};
   logic [15:0] fa [4] = '{16'h0010, 16'h0090, 16'h0050, 16'h0100};
   always #20 clock = ~clock;
   dppr_core_model core (.clock(clock), .bus_rdata(bus_rdata), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_fetch(bus_fetch), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
   dppr_bank uut (.clock(clock), .rst_n(rst_n), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_fetch(bus_fetch), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .illegal_addr_reset(illegal_addr_reset), .port_a_pin_in(pa_in), .port_b_pin_in(pb_in),
      .auto_wakeup_event(aw_ev), .keypad_event(kb_ev), .port_a_out(a_out), .port_a_oe(a_oe),
      .port_a_pullup(a_pu), .osc_out_pin_enable(osc_en), .port_b_out(b_out), .port_b_oe(b_oe),
      .port_b_pullup(b_pu), .keypad_irq_enable(k_en), .keypad_irq_polarity(k_pol),
      .keypad_mode_mask(k_mm));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] unused;
      core.access(1'b0, 1'b1, 1'b0, a, d, unused);
   endtask
   task automatic rd(input logic [15:0] a);
      core.access(1'b1, 1'b0, 1'b0, a, 8'h00, q);
   endtask
   task automatic reset_pulse;
      rst_n = 1'b0;
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      reset_pulse();
      for (int i = 0; i < 7; i++) begin
         rd(ra[i]);
         check(q, 8'h00);
         wr(ra[i], 8'hFF);
         rd(ra[i]);
         check(q, rm[i]);
      end
      check(a_oe, 8'h3B);
      check({osc_en, a_pu[6:0]}, 8'hBF);
      check(k_en, 8'h7F);
      check(k_pol, 8'h3F);
      check(b_oe, 8'hFF);
      check({6'h00, k_mm}, 8'h03);
      // Gaps probed for read-as-zero and for absence of side effects
      for (int i = 0; i < 4; i++) begin
         wr(gp[i], 8'h00);
         rd(gp[i]);
         check(q, 8'h00);
      end
      rd(16'h0005);
      check(q, 8'hFF);
      check(b_pu, 8'hFF);
      wr(16'h0001, 8'hA5);
      rd(16'h0001);
      check(q, 8'hA5);
      pa_in = 6'h04;
      wr(16'h0000, 8'h3B);
      rd(16'h0000);
      check(q, 8'h3F);
      aw_ev = 1'b1;
      repeat (3) @(negedge clock);
      aw_ev = 1'b0;
      rd(16'h0000);
      check(q, 8'h7F);
      kb_ev = 1'b1;
      repeat (3) @(negedge clock);
      kb_ev = 1'b0;
      rd(16'h001A);
      check(q, 8'h0B);
      wr(16'h001A, 8'h04);
      rd(16'h001A);
      check(q, 8'h00);
      wr(16'h0080, 8'h5A);
      wr(16'h00FF, 8'hC3);
      rd(16'h0080);
      check(q, 8'h5A);
      rd(16'h00FF);
      check(q, 8'hC3);
      // Second reset keeps data latches, clears controls
      reset_pulse();
      check(b_out, 8'hA5);
      check(a_out, 8'h3B);
      pb_in = 8'h3C;
      rd(16'h0005);
      check(q, 8'h00);
      rd(16'h000B);
      check(q, 8'h00);
      rd(16'h0001);
      check(q, 8'h3C);
      for (int i = 0; i < 4; i++) begin
         core.access(1'b1, 1'b0, 1'b1, fa[i], 8'h00, q);
         check({7'h00, illegal_addr_reset}, (i > 1) ? 8'h01 : 8'h00);
      end
      summarize();
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         summarize();
      end
   end
endmodule
